//--- inc/sbar_pkg.sv
// shared constants, command codes and carrier types for the bank/read block
package sbar_pkg;

   // pin field widths, bank count and A10 bit index
   localparam int SBAR_ADDR_W = 12;
   localparam int SBAR_BA_W   = 2;
   localparam int SBAR_BANKS  = 4;
   localparam int SBAR_A10    = 10;

   // {ras_n, cas_n, we_n} with chip select low
   localparam logic [2:0] SBAR_OP_ACTIVE = 3'h3;
   localparam logic [2:0] SBAR_OP_READ   = 3'h5;
   localparam logic [2:0] SBAR_OP_WRITE  = 3'h4;
   localparam logic [2:0] SBAR_OP_PRECH  = 3'h2;
   localparam logic [2:0] SBAR_OP_TERM   = 3'h6;
   localparam logic [2:0] SBAR_OP_NOP    = 3'h7;

   // burst length codes; full page is sequential only
   localparam logic [2:0] SBAR_BL_1    = 3'h0;
   localparam logic [2:0] SBAR_BL_2    = 3'h1;
   localparam logic [2:0] SBAR_BL_4    = 3'h2;
   localparam logic [2:0] SBAR_BL_8    = 3'h3;
   localparam logic [2:0] SBAR_BL_FULL = 3'h7;

   // cas latency settings
   localparam logic [1:0] SBAR_CL_2 = 2'h2;
   localparam logic [1:0] SBAR_CL_3 = 2'h3;

   // reset values
   localparam logic [SBAR_BANKS-1:0] SBAR_BANKS_RST = 4'h0;

   typedef enum logic [1:0]
   {
      ENG_IDLE  = 2'h0,
      ENG_READ  = 2'h1,
      ENG_WRITE = 2'h3
   } sbar_eng_t;

   typedef struct packed
   {
      logic                   csN;
      logic                   rasN;
      logic                   casN;
      logic                   weN;
      logic [SBAR_BA_W-1:0]   ba;
      logic [SBAR_ADDR_W-1:0] addr;
      logic                   dqm;
   } sbar_cmd_t;

   typedef struct packed
   {
      logic [1:0] casLat;
      logic [2:0] blCode;
      logic       interleave;
   } sbar_mode_t;

endpackage

//--- hw/sbar_buf.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module sbar_buf #(
   parameter int WIDTH = 8
)(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] slot_q [2];
   logic             wrPtr_q;
   logic             rdPtr_q;
   logic [1:0]       count_q;
   logic             push;
   logic             pop;

   assign inReady  = (count_q != 2'h2);
   assign outValid = (count_q != 2'h0);
   assign outData  = slot_q[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         slot_q[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wrPtr_q <= 1'b0;
         rdPtr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (pop)
         begin
            rdPtr_q <= ~rdPtr_q;
         end
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

//--- hw/sbar_array.sv
// cell storage with one registered read and one write per cycle
`timescale 1ns/1ps
module sbar_array #(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 12
)(
   input  wire logic              ref_clk,
   input  wire logic              rdEn,
   input  wire logic [ADDR_W-1:0] rdAddr,
   output logic      [DATA_W-1:0] rdData,
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic [DATA_W-1:0] wrData
);
   logic [DATA_W-1:0] cells [2**ADDR_W];

   always_ff @(posedge ref_clk)
   begin
      if (wrEn)
      begin
         cells[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rdEn)
      begin
         rdData <= cells[rdAddr];
      end
   end
endmodule

//--- hw/sbar_top.sv
// command decode, bank state, burst engine and read data pipeline
`timescale 1ns/1ps
// Notes on behaviour
// - access needs the bank's row opened first
// - other banks may activate during an access
// - auto-precharge flag closes row after burst
// - first word after cas latency, then each clock
// - data pins float when burst ends
// - full page wraps to column zero
// - new read truncates or chains seamlessly
// - read accepted on every clock
// - output mask acts two clocks later
// - write floats pins if mask preceded it
// - input mask has zero latency
// - precharge ends read burst of same bank
// - timed precharge equals auto-precharge
// - burst terminate stops further column fetches
// - pins drive at n+m-1, valid n+m
// - burst length sets columns per read
module sbar_top
   import sbar_pkg::*;
#(
   parameter int DATA_W      = 32,
   parameter int COL_W       = 8,
   parameter int STORE_ROW_W = 2
)(
   input  wire logic                          ref_clk,
   input  wire logic                          reset,
   input  wire sbar_pkg::sbar_cmd_t           cmd,
   input  wire sbar_pkg::sbar_mode_t          mode,
   input  wire logic [DATA_W-1:0]             dqIn,
   output logic      [DATA_W-1:0]             dqOut,
   output logic                               dqOe,
   output logic      [sbar_pkg::SBAR_BANKS-1:0] bankOpen,
   output logic                               cmdErr,
   output logic                               wrOverrun
);
   import sbar_pkg::*;

   localparam int ADDR_W = SBAR_BA_W + STORE_ROW_W + COL_W;
   localparam int WR_W   = ADDR_W + DATA_W;

   logic [2:0]             op;
   logic                   isAct, isRd, isWr, isPre, isBst;
   logic                   rdOk, wrOk, wrBad, newAcc, stop, cont;
   logic                   outBusy;
   logic [SBAR_BA_W-1:0]   ba;
   logic [COL_W-1:0]       col, beats, bStart, bIdx, curCol;
   logic [SBAR_BA_W-1:0]   bBank;
   logic [SBAR_ADDR_W-1:0] bRow;
   logic                   beatValid, beatRead, full;
   logic                   rdIssue, wrBeat;
   logic [ADDR_W-1:0]      beatAddr;
   logic [DATA_W-1:0]      arrData;
   logic                   selVal;
   logic [DATA_W-1:0]      selData;
   logic                   bufInReady, bufOutValid;
   logic [WR_W-1:0]        bufOutData;

   logic [SBAR_BANKS-1:0]  bankOpen_q;
   logic [SBAR_ADDR_W-1:0] rowAddr_q [SBAR_BANKS];
   sbar_eng_t              state_q;
   logic [SBAR_BA_W-1:0]   engBank_q, apBank_q;
   logic [SBAR_ADDR_W-1:0] engRow_q;
   logic [COL_W-1:0]       start_q, idx_q, left_q;
   logic                   full_q, ap_q, apPend_q;
   logic                   dqm_q, rdVal_q, p2Val_q;
   logic [DATA_W-1:0]      p2Data_q, dqOut_q;
   logic                   dqOe_q, cmdErr_q, wrOverrun_q;

   // column of a beat: wraps within the burst block, or the page when full
   function automatic logic [COL_W-1:0] colOf(input logic [COL_W-1:0] s, input logic [COL_W-1:0] i,
                                              input logic [COL_W-1:0] n, input logic f, input logic il);
      logic [COL_W-1:0] m;
      m = n - 1'b1;
      if (f)
         colOf = s + i;
      else if (il)
         colOf = (s & ~m) | ((s ^ i) & m);
      else
         colOf = (s & ~m) | ((s + i) & m);
   endfunction

   always_comb
   begin
      op    = cmd.csN ? SBAR_OP_NOP : {cmd.rasN, cmd.casN, cmd.weN};
      isAct = (op == SBAR_OP_ACTIVE);
      isRd  = (op == SBAR_OP_READ);
      isWr  = (op == SBAR_OP_WRITE);
      isPre = (op == SBAR_OP_PRECH);
      isBst = (op == SBAR_OP_TERM);
      ba    = cmd.ba;
      col   = cmd.addr[COL_W-1:0];
      full  = (mode.blCode == SBAR_BL_FULL) && !mode.interleave;
      case (mode.blCode)
         SBAR_BL_2: beats = COL_W'(2);
         SBAR_BL_4: beats = COL_W'(4);
         SBAR_BL_8: beats = COL_W'(8);
         default:   beats = COL_W'(1);
      endcase
   end

   // a write cutting into read output is valid only with the mask raised the clock before
   assign outBusy = rdVal_q || p2Val_q || dqOe_q || (state_q == ENG_READ);
   assign wrBad   = outBusy && !dqm_q;
   assign rdOk    = isRd && bankOpen_q[ba];
   assign wrOk    = isWr && bankOpen_q[ba] && !wrBad;
   assign newAcc  = rdOk || wrOk;
   assign stop    = isBst || (isPre && (cmd.addr[SBAR_A10] || ba == engBank_q));
   assign cont    = (state_q != ENG_IDLE) && !newAcc && !stop;

   always_comb
   begin
      beatValid = newAcc || cont;
      beatRead  = newAcc ? rdOk : (state_q == ENG_READ);
      bBank     = newAcc ? ba : engBank_q;
      bRow      = newAcc ? rowAddr_q[ba] : engRow_q;
      bStart    = newAcc ? col : start_q;
      bIdx      = newAcc ? '0 : idx_q;
      curCol    = colOf(bStart, bIdx, beats, (newAcc ? full : full_q), mode.interleave);
      beatAddr  = {bBank, bRow[STORE_ROW_W-1:0], curCol};
      rdIssue   = beatValid && beatRead;
      wrBeat    = beatValid && !beatRead && !cmd.dqm;
   end

   // bank state: open flag and open row per bank
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         bankOpen_q <= SBAR_BANKS_RST;
      end
      else
      begin
         if (apPend_q)
         begin
            bankOpen_q[apBank_q] <= 1'b0;
         end
         if (isPre && cmd.addr[SBAR_A10])
         begin
            bankOpen_q <= SBAR_BANKS_RST;
         end
         else if (isPre)
         begin
            bankOpen_q[ba] <= 1'b0;
         end
         else if (isAct && !bankOpen_q[ba])
         begin
            bankOpen_q[ba] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (isAct && !bankOpen_q[ba])
      begin
         rowAddr_q[ba] <= cmd.addr;
      end
   end

   // burst engine shared by read and write bursts
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q   <= ENG_IDLE;
         engBank_q <= '0;
         engRow_q  <= '0;
         start_q   <= '0;
         idx_q     <= '0;
         left_q    <= '0;
         full_q    <= 1'b0;
         ap_q      <= 1'b0;
         apPend_q  <= 1'b0;
         apBank_q  <= '0;
      end
      else
      begin
         apPend_q <= 1'b0;
         if (newAcc)
         begin
            // a new access replaces the burst in flight
            engBank_q <= ba;
            engRow_q  <= rowAddr_q[ba];
            start_q   <= col;
            idx_q     <= COL_W'(1);
            left_q    <= beats - 1'b1;
            full_q    <= full;
            ap_q      <= cmd.addr[SBAR_A10];
            if (beats == COL_W'(1) && !full)
            begin
               state_q  <= ENG_IDLE;
               apPend_q <= cmd.addr[SBAR_A10];
               apBank_q <= ba;
            end
            else
            begin
               state_q <= rdOk ? ENG_READ : ENG_WRITE;
            end
         end
         else if (stop)
         begin
            state_q <= ENG_IDLE;
         end
         else if (cont)
         begin
            idx_q <= idx_q + 1'b1;
            if (!full_q)
            begin
               left_q <= left_q - 1'b1;
               if (left_q == COL_W'(1))
               begin
                  state_q  <= ENG_IDLE;
                  apPend_q <= ap_q;
                  apBank_q <= engBank_q;
               end
            end
         end
      end
   end

   // error flag: access to idle bank, activate of open bank, invalid write
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cmdErr_q    <= 1'b0;
         wrOverrun_q <= 1'b0;
      end
      else
      begin
         cmdErr_q    <= ((isRd || isWr) && !bankOpen_q[ba]) || (isAct && bankOpen_q[ba]) || (isWr && wrBad);
         wrOverrun_q <= wrBeat && !bufInReady;
      end
   end

   // write beats wait here while the array port is busy with a read fetch;
   // a read of a word still queued returns the old value
   sbar_buf #(
      .WIDTH (WR_W)
   ) u_wbuf (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .inValid  (wrBeat),
      .inReady  (bufInReady),
      .inData   ({beatAddr, dqIn}),
      .outValid (bufOutValid),
      .outReady (!rdIssue),
      .outData  (bufOutData)
   );

   sbar_array #(
      .DATA_W (DATA_W),
      .ADDR_W (ADDR_W)
   ) u_array (
      .ref_clk (ref_clk),
      .rdEn    (rdIssue),
      .rdAddr  (beatAddr),
      .rdData  (arrData),
      .wrEn    (bufOutValid && !rdIssue),
      .wrAddr  (bufOutData[WR_W-1:DATA_W]),
      .wrData  (bufOutData[DATA_W-1:0])
   );

   // read pipeline: fetch at edge n, pins driven from edge n+m-1
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dqm_q   <= 1'b0;
         rdVal_q <= 1'b0;
         p2Val_q <= 1'b0;
      end
      else
      begin
         dqm_q   <= cmd.dqm;
         rdVal_q <= rdIssue && !wrOk;
         p2Val_q <= rdVal_q && !wrOk;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      p2Data_q <= arrData;
   end

   always_comb
   begin
      selVal  = (mode.casLat == SBAR_CL_3) ? p2Val_q : rdVal_q;
      selData = (mode.casLat == SBAR_CL_3) ? p2Data_q : arrData;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dqOe_q  <= 1'b0;
         dqOut_q <= '0;
      end
      else
      begin
         // mask sampled one edge ago gates this edge: two clocks to the pins
         dqOe_q  <= selVal && !dqm_q && !wrOk;
         dqOut_q <= selData;
      end
   end

   assign dqOut     = dqOut_q;
   assign dqOe      = dqOe_q;
   assign bankOpen  = bankOpen_q;
   assign cmdErr    = cmdErr_q;
   assign wrOverrun = wrOverrun_q;

   a_idle_access_err: assert property (@(posedge ref_clk) disable iff (reset)
      (isRd || isWr) && !bankOpen_q[ba] |=> cmdErr_q && !rdVal_q)
      else $error("access to idle bank not flagged");

   a_cl2_first_word: assert property (@(posedge ref_clk) disable iff (reset)
      (rdOk && mode.casLat == SBAR_CL_2 && !cmd.dqm) ##1 (!wrOk && mode.casLat == SBAR_CL_2) |=> dqOe_q)
      else $error("latency two read word not driven");

   a_cl3_first_word: assert property (@(posedge ref_clk) disable iff (reset)
      (rdOk && mode.casLat == SBAR_CL_3) ##1 (!wrOk && !cmd.dqm) ##1 (!wrOk && mode.casLat == SBAR_CL_3)
      |=> dqOe_q)
      else $error("latency three read word not driven");

   a_write_floats: assert property (@(posedge ref_clk) disable iff (reset)
      wrOk |=> !dqOe_q && !rdVal_q)
      else $error("pins driven after write");

   a_mask_two_clk: assert property (@(posedge ref_clk) disable iff (reset)
      cmd.dqm |-> ##2 !dqOe_q)
      else $error("output mask latency wrong");

   a_release_idle: assert property (@(posedge ref_clk) disable iff (reset)
      (!rdVal_q && !p2Val_q) |=> !dqOe_q)
      else $error("pins not released after burst");

   a_auto_pre_close: assert property (@(posedge ref_clk) disable iff (reset)
      apPend_q |=> !bankOpen_q[$past(apBank_q)])
      else $error("auto precharge did not close row");

   a_page_wrap: assert property (@(posedge ref_clk) disable iff (reset)
      (cont && full_q && curCol == '1) ##1 cont |-> curCol == '0)
      else $error("full page did not wrap");

   a_term_stops: assert property (@(posedge ref_clk) disable iff (reset)
      (isBst && !newAcc) |=> state_q == ENG_IDLE ##1 !rdVal_q)
      else $error("terminate did not stop fetches");

   a_read_each_clk: assert property (@(posedge ref_clk) disable iff (reset)
      rdOk [*3] |=> rdVal_q)
      else $error("back to back read dropped");

   c_cl3_read: cover property (@(posedge ref_clk) disable iff (reset) rdOk && mode.casLat == SBAR_CL_3);
   c_read_to_write: cover property (@(posedge ref_clk) disable iff (reset) dqOe_q ##1 cmd.dqm ##1 wrOk);
   c_auto_pre: cover property (@(posedge ref_clk) disable iff (reset) apPend_q);
   c_page_wrap: cover property (@(posedge ref_clk) disable iff (reset) cont && full_q && curCol == '1);
endmodule

//--- bench/sbar_ctrl_model.sv
// controller-side model: commands and write data launched at the falling edge
`timescale 1ns/1ps
module sbar_ctrl_model #(
   parameter int DATA_W  = 32,
   parameter int ACC_DLY = 2,
   parameter int RCV_DLY = 2
)(
   input  wire logic                ref_clk,
   output sbar_pkg::sbar_cmd_t      cmd,
   output logic        [DATA_W-1:0] dqIn
);
   import sbar_pkg::*;
   initial
   begin
      cmd  = sbar_cmd_t'({1'b0, SBAR_OP_NOP, 15'h0});
      dqIn = '0;
   end
   // released data lines toggle so a stale word never passes as fresh
   task automatic put(input logic [2:0] op, input logic [1:0] ba, input logic [11:0] addr,
                      input logic dqm, input logic [DATA_W-1:0] d);
      @(negedge ref_clk);
      cmd  = sbar_cmd_t'({1'b0, op, ba, addr, dqm});
      dqIn = (op == SBAR_OP_WRITE) ? d : ~dqIn;
   endtask
   task automatic idle(input int n, input logic dqm);
      repeat (n) put(SBAR_OP_NOP, 2'h0, 12'h0, dqm, '0);
   endtask
   // opens a row, then holds off access for the activate delay
   task automatic act(input logic [1:0] ba, input logic [11:0] row);
      put(SBAR_OP_ACTIVE, ba, row, 1'b0, '0);
      idle(ACC_DLY - 1, 1'b0);
   endtask
   // closes a row and waits out recovery before reuse
   task automatic pre(input logic [1:0] ba);
      put(SBAR_OP_PRECH, ba, 12'h0, 1'b0, '0);
      idle(RCV_DLY, 1'b0);
   endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for bank activation and read bursts
`timescale 1ns/1ps
module tb_top;
   import sbar_pkg::*;
   localparam int DW = 32;
   logic                  ref_clk;
   logic                  reset;
   sbar_cmd_t             cmd;
   sbar_mode_t            mode;
   logic [DW-1:0]         dqIn;
   logic [DW-1:0]         dqOut;
   logic                  dqOe;
   logic                  cmdErr;
   logic                  wrOverrun;
   logic [SBAR_BANKS-1:0] bankOpen;
   int                    num_errors = 0;
   int                    comparisons = 0;
   int                    cyc = 0;
   int                    rdEdge = 0;
   int                    firstEdge;
   int                    lastEdge;
   logic [DW-1:0]         words[$];

   sbar_top #(.DATA_W(DW)) i_sbar_top (.ref_clk(ref_clk), .reset(reset), .cmd(cmd), .mode(mode),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .bankOpen(bankOpen), .cmdErr(cmdErr),
      .wrOverrun(wrOverrun));
   sbar_ctrl_model #(.DATA_W(DW)) i_sbar_ctrl_model (.ref_clk(ref_clk), .cmd(cmd), .dqIn(dqIn));

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // -----------------------------
   // read data capture and checks
   // -----------------------------
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (dqOe === 1'b1)
      begin
         if (words.size() == 0)
            firstEdge = cyc + 1;
         lastEdge = cyc + 1;
         words.push_back(dqOut);
      end
   end

   task automatic test_done;
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // word stored at bank b, column c
   function automatic logic [DW-1:0] pat(input logic [1:0] b, input logic [7:0] c);
      return {8'h5a, 6'h0, b, 8'h3c, c};
   endfunction

   task automatic rd(input logic [1:0] ba, input logic [7:0] col, input logic ap);
      i_sbar_ctrl_model.put(SBAR_OP_READ, ba, {1'b0, ap, 2'h0, col}, 1'b0, '0);
      if (rdEdge == 0)
         rdEdge = cyc + 1;
   endtask

   task automatic wr(input logic [1:0] ba, input logic [7:0] col, input logic [DW-1:0] d);
      i_sbar_ctrl_model.put(SBAR_OP_WRITE, ba, {4'h0, col}, 1'b0, d);
   endtask

   // entries are {bank, column}; words must arrive unbroken
   task automatic expect_words(input logic [9:0] ex[$]);
      i_sbar_ctrl_model.idle(12, 1'b0);
      chk(DW'(words.size()), DW'(ex.size()));
      chk(DW'(firstEdge - rdEdge), DW'(mode.casLat));
      chk(DW'(lastEdge - firstEdge + 1), DW'(words.size()));
      foreach (ex[i])
         if (i < words.size())
            chk(words[i], pat(ex[i][9:8], ex[i][7:0]));
      words.delete();
      rdEdge = 0;
   endtask

   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_fill;
      mode = '{SBAR_CL_2, SBAR_BL_1, 1'b0};
      i_sbar_ctrl_model.act(2'h0, 12'h0);
      i_sbar_ctrl_model.act(2'h2, 12'h1);
      chk(DW'(bankOpen), DW'(4'h5));
      for (int c = 0; c < 8; c++)
         wr(2'h0, c[7:0], pat(2'h0, c[7:0]));
      for (int c = 0; c < 4; c++)
         wr(2'h2, c[7:0], pat(2'h2, c[7:0]));
      wr(2'h0, 8'hfe, pat(2'h0, 8'hfe));
      wr(2'h0, 8'hff, pat(2'h0, 8'hff));
      i_sbar_ctrl_model.idle(4, 1'b0);
      chk(DW'(wrOverrun), DW'(0));
      chk(DW'(cmdErr), DW'(0));
   endtask

   task automatic t_refuse;
      rd(2'h1, 8'h0, 1'b0);
      i_sbar_ctrl_model.idle(1, 1'b0);
      chk(DW'(cmdErr), DW'(1));
      i_sbar_ctrl_model.act(2'h0, 12'h3);
      chk(DW'(cmdErr), DW'(1));
      i_sbar_ctrl_model.idle(6, 1'b0);
      chk(DW'(bankOpen), DW'(4'h5));
      chk(DW'(words.size()), DW'(0));
      rdEdge = 0;
   endtask

   task automatic t_bursts;
      mode = '{SBAR_CL_2, SBAR_BL_4, 1'b0};
      rd(2'h0, 8'h1, 1'b0);
      expect_words('{10'h001, 10'h002, 10'h003, 10'h000});
      mode = '{SBAR_CL_3, SBAR_BL_8, 1'b1};
      rd(2'h0, 8'h5, 1'b0);
      expect_words('{10'h005, 10'h004, 10'h007, 10'h006, 10'h001, 10'h000, 10'h003, 10'h002});
      mode = '{SBAR_CL_2, SBAR_BL_2, 1'b0};
      rd(2'h2, 8'h1, 1'b0);
      expect_words('{10'h201, 10'h200});
   endtask

   task automatic t_fullpage;
      mode = '{SBAR_CL_2, SBAR_BL_FULL, 1'b0};
      rd(2'h0, 8'hfe, 1'b0);
      i_sbar_ctrl_model.idle(3, 1'b0);
      i_sbar_ctrl_model.put(SBAR_OP_TERM, 2'h0, 12'h0, 1'b0, '0);
      expect_words('{10'h0fe, 10'h0ff, 10'h000, 10'h001});
   endtask

   task automatic t_chain;
      mode = '{SBAR_CL_2, SBAR_BL_4, 1'b0};
      rd(2'h0, 8'h0, 1'b0);
      i_sbar_ctrl_model.idle(1, 1'b0);
      rd(2'h2, 8'h0, 1'b0);
      expect_words('{10'h000, 10'h001, 10'h200, 10'h201, 10'h202, 10'h203});
      mode = '{SBAR_CL_2, SBAR_BL_1, 1'b0};
      rd(2'h0, 8'h7, 1'b0);
      rd(2'h2, 8'h3, 1'b0);
      rd(2'h0, 8'hfe, 1'b0);
      expect_words('{10'h007, 10'h203, 10'h0fe});
   endtask

   task automatic t_prech;
      mode = '{SBAR_CL_3, SBAR_BL_8, 1'b0};
      rd(2'h0, 8'h0, 1'b0);
      i_sbar_ctrl_model.idle(2, 1'b0);
      i_sbar_ctrl_model.pre(2'h0);
      expect_words('{10'h000, 10'h001, 10'h002});
      chk(DW'(bankOpen), DW'(4'h4));
      mode = '{SBAR_CL_2, SBAR_BL_4, 1'b0};
      rd(2'h2, 8'h0, 1'b1);
      expect_words('{10'h200, 10'h201, 10'h202, 10'h203});
      chk(DW'(bankOpen), DW'(4'h0));
      i_sbar_ctrl_model.act(2'h2, 12'h1);
      rd(2'h2, 8'h0, 1'b0);
      i_sbar_ctrl_model.idle(3, 1'b0);
      i_sbar_ctrl_model.pre(2'h2);
      expect_words('{10'h200, 10'h201, 10'h202, 10'h203});
      chk(DW'(bankOpen), DW'(4'h0));
   endtask

   task automatic t_rd2wr;
      i_sbar_ctrl_model.act(2'h0, 12'h0);
      mode = '{SBAR_CL_2, SBAR_BL_8, 1'b0};
      rd(2'h0, 8'h0, 1'b0);
      i_sbar_ctrl_model.idle(1, 1'b0);
      i_sbar_ctrl_model.idle(2, 1'b1);
      i_sbar_ctrl_model.put(SBAR_OP_WRITE, 2'h0, 12'h3, 1'b0, pat(2'h1, 8'h3));
      i_sbar_ctrl_model.idle(1, 1'b1);
      chk(DW'(cmdErr), DW'(0));
      i_sbar_ctrl_model.idle(6, 1'b1);
      expect_words('{10'h000, 10'h001});
      mode = '{SBAR_CL_2, SBAR_BL_4, 1'b0};
      rd(2'h0, 8'h0, 1'b0);
      i_sbar_ctrl_model.idle(1, 1'b0);
      wr(2'h0, 8'h0, pat(2'h1, 8'h0));
      i_sbar_ctrl_model.idle(1, 1'b0);
      chk(DW'(cmdErr), DW'(1));
      i_sbar_ctrl_model.idle(10, 1'b0);
      words.delete();
      rdEdge = 0;
      mode = '{SBAR_CL_2, SBAR_BL_1, 1'b0};
      rd(2'h0, 8'h3, 1'b0);
      rd(2'h0, 8'h0, 1'b0);
      expect_words('{10'h103, 10'h000});
   endtask

   initial
   begin
      reset = 1'b1;
      mode = '{SBAR_CL_2, SBAR_BL_1, 1'b0};
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(DW'({dqOe, cmdErr, wrOverrun, bankOpen}), DW'(0));
      chk(dqOut, DW'(0));
      reset = 1'b0;
      t_fill;
      t_refuse;
      t_bursts;
      t_fullpage;
      t_chain;
      t_prech;
      t_rd2wr;
      test_done;
   end

   // whole run is a few hundred cycles
   initial
   begin
      repeat (4000) @(posedge ref_clk);
      num_errors++;
      test_done;
   end
endmodule
